// ===== rtl/vds_pkg.sv
/*
 * Constants for the line slicer of the vertical blanking interval: register
 * offsets, field positions, reset values, per-standard rate and framing tables.
 * Assumes a single 20 MHz decoder clock drives every consumer.
 */
// Functional notes
// - Recover bit phase in run-in, slice, assemble bytes
// - Two line sections of 56 bytes each
// - Global register: clock, source, field rate, errors; only source and errors decoded
// - Two 4-bit standards per line, lines 2-24
// - Line 24 selection covers the rest of field
// - 11-bit horizontal, 9-bit vertical, 1-bit field offsets
// - Offsets counted from reference falling edges
// - Teletext codes 0000, 0100, 1000 with Hamming
// - Closed caption codes 0001, 0101, framing 001
// - Programme delivery 9951h, wide screen 1E3C1Fh
// - Time codes 1001, 1010, programmable framing
// - Codes 1100, 1101, 1110 supported; 1011 reserved
// - Codes 0110, 0111 no framing; 1111 passes video
package vds_pkg;
   // =======================================================================
   // Timing and sizes
   localparam int unsigned CLOCK_HZ    = 20_000_000;
   localparam int unsigned SECT_BYTES  = 56;
   localparam int unsigned NUM_LINES   = 23;
   localparam int unsigned RUNIN_EDGES = 6;

   // =======================================================================
   // Register offsets
   localparam logic [7:0] OFS_GLOBAL_CFG   = 8'h40;
   localparam logic [7:0] OFS_LINE_FIRST   = 8'h41;
   localparam logic [7:0] OFS_LINE_LAST    = 8'h57;
   localparam logic [7:0] OFS_SLICER_HORIZ_OFFSET_LOW     = 8'h59;
   localparam logic [7:0] OFS_SLICER_VERT_OFFSET_LOW     = 8'h5A;
   localparam logic [7:0] OFS_OFF_HIGH     = 8'h5B;
   localparam logic [7:0] OFS_PROG_FRAMING = 8'h5C;
   localparam logic [7:0] OFS_STATUS       = 8'h5D;
   localparam logic [7:0] OFS_DATA_TYPE    = 8'h62;

   // =======================================================================
   // Field positions and reset values
   localparam int unsigned CFG_SOURCE_BIT = 6;
   localparam int unsigned CFG_ERR_LSB    = 0;
   localparam int unsigned CFG_ERR_W      = 2;
   localparam int unsigned OFF_HHI_LSB    = 0;
   localparam int unsigned OFF_VHI_BIT    = 4;
   localparam int unsigned OFF_FIELD_BIT  = 7;
   localparam int unsigned DT_HAMM_BIT    = 4;
   localparam logic [7:0]  RST_LINE_SEL   = 8'hFF;
   localparam logic [7:0]  RST_ZERO       = 8'h00;
   localparam logic [7:0]  RST_PROG_FC    = 8'hA7;

   // =======================================================================
   // Standards
   typedef enum logic [3:0] {
      STD_TTX625 = 4'h0, STD_CC625 = 4'h1, STD_PDC = 4'h2, STD_WSS = 4'h3,
      STD_TTX525 = 4'h4, STD_CC525 = 4'h5, STD_VIDEO = 4'h6, STD_RAW = 4'h7,
      STD_TTXGEN = 4'h8, STD_TC625 = 4'h9, STD_TC525 = 4'hA, STD_RSVD = 4'hB,
      STD_NABTS = 4'hC, STD_JTEXT = 4'hD, STD_JSWITCH = 4'hE, STD_NONE = 4'hF
   } vds_std_t;

   localparam int unsigned STD_RATE_BPS [16] = '{
      6_937_500, 500_000, 5_000_000, 5_000_000, 5_727_200, 503_000,
      5_000_000, 5_000_000, 6_937_500, 1_812_500, 1_789_800, 5_000_000,
      5_727_200, 5_727_200, 5_000_000, 5_000_000};
   // Fixed framing codes, received first bit in the LSB
   localparam logic [23:0] STD_FC_CODE [16] = '{
      24'h000027, 24'h000001, 24'h009951, 24'h1E3C1F, 24'h000027, 24'h000001,
      24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0, 24'h0};
   localparam logic [4:0] STD_FC_LEN [16] = '{
      5'd8, 5'd3, 5'd16, 5'd24, 5'd8, 5'd3, 5'd0, 5'd0,
      5'd8, 5'd8, 5'd8, 5'd0, 5'd8, 5'd8, 5'd8, 5'd0};
   localparam logic [7:0] STD_FC_WIN [16] = '{
      8'd16, 8'd8, 8'd24, 8'd32, 8'd16, 8'd8, 8'd0, 8'd0,
      8'd16, 8'd16, 8'd16, 8'd0, 8'd16, 8'd16, 8'hFF, 8'd0};

   // Phase step per clock for a 16-bit accumulator
   function automatic logic [15:0] rateInc(input logic [3:0] s);
      return 16'((64'(STD_RATE_BPS[s]) * 64'd65536) / 64'(CLOCK_HZ));
   endfunction
endpackage

// ===== rtl/vds_slicer.sv
/*
 * Line slicer: bit phase recovery, framing search, byte assembly, two line
 * sections and an output FIFO toward the text store.
 * Assumes samples, references and register strobes synchronous to clock.
 */
`timescale 1ns/1ps

// ==========================================================================
// Output FIFO
module vds_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input  wire logic             clock,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : gBad
         $error("vds_fifo depth must be a power of two");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wrPtr_q;
   logic [AW-1:0]    rdPtr_q;
   logic [AW:0]      count_q;
   logic             push;
   logic             pop;

   assign inReady  = count_q != (AW+1)'(DEPTH);
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   assign outValid = count_q != '0;
   assign outData  = mem[rdPtr_q];

   always_ff @(posedge clock) begin
      if (push) begin
         mem[wrPtr_q] <= inData;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         wrPtr_q <= wrPtr_q + AW'(push);
         rdPtr_q <= rdPtr_q + AW'(pop);
         count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // vds_fifo

// ==========================================================================
// Slicer top
module vds_slicer #(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] sampleA,
   input  wire logic [7:0] sampleB,
   input  wire logic       horizRef,
   input  wire logic       vertRef,
   input  wire logic       fieldId,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWr,
   input  wire logic       regRd,
   output logic      [7:0] regRdData,
   output logic      [7:0] textData,
   output logic            textLast,
   output logic            textValid,
   input  wire logic       textReady
);
   typedef enum {S_IDLE, S_WAITH, S_RUNIN, S_FRAME, S_DATA} vds_state_t;

   // =======================================================================
   // Registers
   logic [7:0]  globalCfg_q;
   logic [7:0]  lineSel_q [vds_pkg::NUM_LINES];
   logic [7:0]  hoffLow_q;
   logic [7:0]  voffLow_q;
   logic [7:0]  offHigh_q;
   logic [7:0]  progFc_q;
   logic [7:0]  dataType_q;
   logic [3:0]  lostCnt_q;
   logic [1:0]  secFull_q;
   logic [3:0]  curStd;
   vds_state_t  state_q;

   logic [10:0] hOffset;
   logic [8:0]  vOffset;
   assign hOffset = {offHigh_q[vds_pkg::OFF_HHI_LSB +: 3], hoffLow_q};
   assign vOffset = {offHigh_q[vds_pkg::OFF_VHI_BIT], voffLow_q};

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         globalCfg_q <= vds_pkg::RST_ZERO;
         hoffLow_q   <= vds_pkg::RST_ZERO;
         voffLow_q   <= vds_pkg::RST_ZERO;
         offHigh_q   <= vds_pkg::RST_ZERO;
         progFc_q    <= vds_pkg::RST_PROG_FC;
         dataType_q  <= vds_pkg::RST_ZERO;
         for (int i = 0; i < vds_pkg::NUM_LINES; i++) begin
            lineSel_q[i] <= vds_pkg::RST_LINE_SEL;
         end
      end else if (regWr) begin
         unique case (regAddr)
            vds_pkg::OFS_GLOBAL_CFG:   globalCfg_q <= regWrData;
            vds_pkg::OFS_SLICER_HORIZ_OFFSET_LOW:     hoffLow_q   <= regWrData;
            vds_pkg::OFS_SLICER_VERT_OFFSET_LOW:     voffLow_q   <= regWrData;
            vds_pkg::OFS_OFF_HIGH:     offHigh_q   <= regWrData;
            vds_pkg::OFS_PROG_FRAMING: progFc_q    <= regWrData;
            vds_pkg::OFS_DATA_TYPE:    dataType_q  <= regWrData;
            default: begin
               if (regAddr >= vds_pkg::OFS_LINE_FIRST && regAddr <= vds_pkg::OFS_LINE_LAST) begin
                  lineSel_q[5'(regAddr - vds_pkg::OFS_LINE_FIRST)] <= regWrData;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regRdData <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            vds_pkg::OFS_GLOBAL_CFG:   regRdData <= globalCfg_q;
            vds_pkg::OFS_SLICER_HORIZ_OFFSET_LOW:     regRdData <= hoffLow_q;
            vds_pkg::OFS_SLICER_VERT_OFFSET_LOW:     regRdData <= voffLow_q;
            vds_pkg::OFS_OFF_HIGH:     regRdData <= offHigh_q;
            vds_pkg::OFS_PROG_FRAMING: regRdData <= progFc_q;
            vds_pkg::OFS_STATUS:
               regRdData <= {lostCnt_q, 1'b0, state_q != S_IDLE, secFull_q};
            vds_pkg::OFS_DATA_TYPE:    regRdData <= {dataType_q[7:4], curStd};
            default: begin
               if (regAddr >= vds_pkg::OFS_LINE_FIRST && regAddr <= vds_pkg::OFS_LINE_LAST) begin
                  regRdData <= lineSel_q[5'(regAddr - vds_pkg::OFS_LINE_FIRST)];
               end else begin
                  regRdData <= '0;
               end
            end
         endcase
      end
   end

   // =======================================================================
   // Reference edges, line and sample counters
   logic        hPrev_q;
   logic        vPrev_q;
   logic        hFall;
   logic        vFall;
   logic [10:0] hCnt_q;
   logic [8:0]  vCnt_q;
   logic        fieldPar_q;
   assign hFall = hPrev_q && !horizRef;
   assign vFall = vPrev_q && !vertRef;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hPrev_q    <= 1'b0;
         vPrev_q    <= 1'b0;
         hCnt_q     <= '0;
         vCnt_q     <= '0;
         fieldPar_q <= 1'b0;
      end else begin
         hPrev_q <= horizRef;
         vPrev_q <= vertRef;
         hCnt_q  <= hFall ? '0 : (hCnt_q == '1 ? hCnt_q : hCnt_q + 11'd1);
         if (vFall) begin
            vCnt_q     <= '0;
            fieldPar_q <= fieldId ^ offHigh_q[vds_pkg::OFF_FIELD_BIT];
         end else if (hFall && vCnt_q != '1) begin
            vCnt_q <= vCnt_q + 9'd1;
         end
      end
   end

   // Line number relative to the vertical trigger; 24 and beyond share one
   logic [8:0] lineNum;
   logic [4:0] selIdx;
   logic [7:0] selByte;
   logic       lineValid;
   always_comb begin
      lineNum   = vCnt_q - vOffset;
      lineValid = vCnt_q >= vOffset && lineNum >= 9'd2;
      selIdx    = lineNum >= 9'd24 ? 5'(vds_pkg::NUM_LINES - 1) : 5'(lineNum - 9'd2);
      selByte   = lineSel_q[selIdx];
      curStd    = fieldPar_q ? selByte[7:4] : selByte[3:0];
   end

   // =======================================================================
   // Slicing level and bit clock
   logic [7:0]  sample;
   logic [7:0]  maxS_q;
   logic [7:0]  minS_q;
   logic        bitLvl;
   logic        bitPrev_q;
   logic [15:0] phase_q;
   logic [16:0] phaseSum;
   logic        bitStrobe;
   logic [3:0]  std_q;
   assign sample    = globalCfg_q[vds_pkg::CFG_SOURCE_BIT] ? sampleB : sampleA;
   assign bitLvl    = sample > 8'((9'(maxS_q) + 9'(minS_q)) >> 1);
   assign phaseSum  = 17'(phase_q) + 17'(vds_pkg::rateInc(std_q));
   assign bitStrobe = state_q != S_RUNIN && state_q != S_IDLE && phaseSum[16];

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         maxS_q    <= '0;
         minS_q    <= '1;
         bitPrev_q <= 1'b0;
         phase_q   <= '0;
      end else begin
         bitPrev_q <= bitLvl;
         if (state_q == S_WAITH) begin
            maxS_q <= '0;
            minS_q <= '1;
         end else if (state_q == S_RUNIN) begin
            if (sample > maxS_q) maxS_q <= sample;
            if (sample < minS_q) minS_q <= sample;
         end
         // Each run-in edge puts the next sample point half a bit later
         if (state_q == S_RUNIN && bitLvl != bitPrev_q) begin
            phase_q <= 16'h8000;
         end else begin
            phase_q <= phaseSum[15:0];
         end
      end
   end

   // =======================================================================
   // Line state machine
   logic [23:0] frameSh_q;
   logic [7:0]  winCnt_q;
   logic [3:0]  edgeCnt_q;
   logic [7:0]  byteSh_q;
   logic [2:0]  bitCnt_q;
   logic [5:0]  wrIdx_q;
   logic        wrSec_q;
   logic [2:0]  errCnt_q;
   logic [7:0]  lineMem [2 * vds_pkg::SECT_BYTES];
   logic [5:0]  secLen_q [2];
   logic [23:0] frameNext;
   logic [4:0]  fcLen;
   logic [23:0] fcCode;
   logic        fcHit;
   logic [7:0]  byteNext;
   logic        byteDone;
   logic        hammOn;
   logic        commit;
   logic        discard;

   always_comb begin
      frameNext = {bitLvl, frameSh_q[23:1]};
      fcLen     = vds_pkg::STD_FC_LEN[std_q];
      fcCode    = vds_pkg::STD_FC_LEN[std_q] != 5'd0 && vds_pkg::STD_FC_CODE[std_q] == '0
                ? {16'h0, progFc_q} : vds_pkg::STD_FC_CODE[std_q];
      fcHit     = (frameNext >> (5'd24 - fcLen)) == fcCode;
      byteNext  = {bitLvl, byteSh_q[7:1]};
      byteDone  = bitStrobe && state_q == S_DATA && bitCnt_q == 3'd7;
      hammOn    = std_q == 4'h0 || std_q == 4'h4 ||
                  ((std_q == 4'h8 || std_q == 4'hC) && dataType_q[vds_pkg::DT_HAMM_BIT]);
      commit    = state_q == S_DATA && (hFall || (byteDone && wrIdx_q == 6'(vds_pkg::SECT_BYTES - 1)))
                  && wrIdx_q != '0;
      discard   = 3'(globalCfg_q[vds_pkg::CFG_ERR_LSB +: vds_pkg::CFG_ERR_W]) < errCnt_q;
   end

   always_ff @(posedge clock) begin
      if (byteDone) begin
         lineMem[{wrSec_q, wrIdx_q} - (wrSec_q ? 7'(64 - vds_pkg::SECT_BYTES) : 7'd0)] <= byteNext;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_q   <= S_IDLE;
         std_q     <= vds_pkg::STD_NONE;
         frameSh_q <= '0;
         winCnt_q  <= '0;
         edgeCnt_q <= '0;
         byteSh_q  <= '0;
         bitCnt_q  <= '0;
         wrIdx_q   <= '0;
         errCnt_q  <= '0;
      end else begin
         unique case (state_q)
            S_IDLE: begin
               // 1111 and 1011 never open a line, nor does a full write section
               if (hFall && lineValid && curStd != 4'hF && curStd != 4'hB
                   && !secFull_q[wrSec_q]) begin
                  std_q   <= curStd;
                  state_q <= S_WAITH;
               end
            end
            S_WAITH: begin
               if (hCnt_q == hOffset) begin
                  edgeCnt_q <= '0;
                  state_q   <= S_RUNIN;
               end
            end
            S_RUNIN: begin
               if (bitLvl != bitPrev_q) edgeCnt_q <= edgeCnt_q + 4'd1;
               if (edgeCnt_q == 4'(vds_pkg::RUNIN_EDGES)) begin
                  winCnt_q <= '0;
                  wrIdx_q  <= '0;
                  errCnt_q <= '0;
                  bitCnt_q <= '0;
                  state_q  <= fcLen == 5'd0 ? S_DATA : S_FRAME;
               end
               // Line without run-in ends at the next reference fall
               if (hFall) state_q <= S_IDLE;
            end
            S_FRAME: begin
               if (bitStrobe) begin
                  frameSh_q <= frameNext;
                  winCnt_q  <= winCnt_q + 8'd1;
                  if (fcHit && winCnt_q + 8'd1 >= 8'(fcLen)) state_q <= S_DATA;
                  else if (winCnt_q == vds_pkg::STD_FC_WIN[std_q]) state_q <= S_IDLE;
               end
               if (hFall) state_q <= S_IDLE;
            end
            S_DATA: begin
               if (bitStrobe) begin
                  byteSh_q <= byteNext;
                  bitCnt_q <= bitCnt_q + 3'd1;
               end
               if (byteDone) begin
                  wrIdx_q <= wrIdx_q + 6'd1;
                  if (hammOn && !(^byteNext) && errCnt_q != '1) errCnt_q <= errCnt_q + 3'd1;
               end
               if (hFall || commit) state_q <= S_IDLE;
            end
         endcase
      end
   end

   // =======================================================================
   // Section ownership and drain
   logic       rdSec_q;
   logic [5:0] rdIdx_q;
   logic       fifoReady;
   logic       drainGo;
   logic       doCommit;
   logic       doneDrain;
   assign drainGo   = secFull_q[rdSec_q] && fifoReady;
   assign doCommit  = commit && !discard;
   assign doneDrain = drainGo && rdIdx_q == secLen_q[rdSec_q] - 6'd1;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         secFull_q   <= '0;
         secLen_q[0] <= '0;
         secLen_q[1] <= '0;
         wrSec_q     <= 1'b0;
         rdSec_q     <= 1'b0;
         rdIdx_q     <= '0;
         lostCnt_q   <= '0;
      end else begin
         for (int s = 0; s < 2; s++) begin
            // Commit into a section wins over its drain finishing
            if (doCommit && wrSec_q == 1'(s)) begin
               secFull_q[s] <= 1'b1;
               secLen_q[s]  <= byteDone ? wrIdx_q + 6'd1 : wrIdx_q;
            end else if (doneDrain && rdSec_q == 1'(s)) begin
               secFull_q[s] <= 1'b0;
            end
         end
         if (doCommit) wrSec_q <= !wrSec_q;
         if (commit && discard) lostCnt_q <= lostCnt_q + 4'd1;
         if (drainGo) rdIdx_q <= doneDrain ? '0 : rdIdx_q + 6'd1;
         if (doneDrain) rdSec_q <= !rdSec_q;
      end
   end

   vds_fifo #(
      .WIDTH (9),
      .DEPTH (FIFO_DEPTH)
   ) uFifo (
      .clock    (clock),
      .rst      (rst),
      .inData   ({doneDrain, lineMem[{rdSec_q, rdIdx_q} - (rdSec_q ? 7'(64 - vds_pkg::SECT_BYTES) : 7'd0)]}),
      .inValid  (drainGo),
      .inReady  (fifoReady),
      .outData  ({textLast, textData}),
      .outValid (textValid),
      .outReady (textReady)
   );
endmodule // vds_slicer

// ===== tb/vds_slicer_monitor.sv
/* Port assertions for the slicer.
   Bound to every vds_slicer; sees its ports only. */
`timescale 1ns/1ps
module vds_slicer_monitor (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWr,
   input wire logic       regRd,
   input wire logic [7:0] regRdData,
   input wire logic [7:0] textData,
   input wire logic       textLast,
   input wire logic       textValid,
   input wire logic       textReady
);
   // ==================================================
   // Helpers
   logic       rwAddr;
   logic [6:0] lineBytes_q;
   assign rwAddr = regAddr >= 8'h40 && regAddr <= 8'h5C && regAddr != 8'h58;
   // Bytes taken so far in the current line
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lineBytes_q <= 7'h00;
      end else if (textValid && textReady) begin
         lineBytes_q <= textLast ? 7'h00 : lineBytes_q + 7'h01;
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   // ==================================================
   // Assertions
   a_unmapped_zero: assert property (
      regRd && (regAddr < 8'h40 || regAddr == 8'h58 || regAddr > 8'h62) |=> regRdData == 8'h00)
      else $error("unmapped register read not zero");
   a_write_readback: assert property (
      $past(regWr) && !$past(regRd) && regRd && rwAddr && regAddr == $past(regAddr)
      |=> regRdData == $past(regWrData, 2)) else $error("read after write differs");
   a_type_upper: assert property (
      $past(regWr) && regRd && regAddr == 8'h62 && $past(regAddr) == 8'h62
      |=> (regRdData & 8'hF0) == ($past(regWrData, 2) & 8'hF0)) else $error("type bits lost");
   a_reread_same: assert property (
      regRd && $past(regRd) && !$past(regWr) && rwAddr && regAddr == $past(regAddr)
      |=> regRdData == $past(regRdData)) else $error("second read differs");
   a_read_holds: assert property (
      !regRd |=> $stable(regRdData)) else $error("read data moved without read");
   a_text_stands: assert property (
      textValid && !textReady |=> textValid && $stable(textData) && $stable(textLast))
      else $error("text byte changed before taken");
   a_valid_kept: assert property (
      $fell(textValid) |-> $past(textReady)) else $error("text valid dropped untaken");
   a_line_max: assert property (
      textValid && textReady |-> lineBytes_q < 7'd56) else $error("line longer than section");
endmodule // vds_slicer_monitor

bind vds_slicer vds_slicer_monitor u_mon (.clock(clock), .rst(rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .textData(textData), .textLast(textLast), .textValid(textValid), .textReady(textReady));

// ===== tb/vds_video_src.sv
/* Decoder front-end model: references and sliceable samples per field.
   Run by task calls from the bench; outputs change at falling edges. */
`timescale 1ns/1ps
module vds_video_src #(
   parameter int LINE_CLKS = 960,
   parameter int LINES     = 25
) (
   input  wire logic       clock,
   output logic      [7:0] sampleA,
   output logic      [7:0] sampleB,
   output logic            horizRef,
   output logic            vertRef,
   output logic            fieldId
);
   initial begin
      sampleA = 8'h40;
      sampleB = 8'h40;
      horizRef = 1'b1;
      vertRef = 1'b1;
      fieldId = 1'b0;
   end
   // ==================================================
   // One field: 16 run-in bits then random data at 4 clocks a bit
   task automatic run_field(input logic onB, input logic fid);
      int l;
      int c;
      int k;
      logic [31:0] bits;
      logic [7:0]  lvl;
      fieldId = fid;
      vertRef = 1'b1;
      repeat (LINE_CLKS) @(negedge clock);
      vertRef = 1'b0;
      for (l = 0; l < LINES; l++) begin
         bits = $urandom;
         horizRef = 1'b1;
         repeat (64) @(negedge clock);
         horizRef = 1'b0;
         for (c = 64; c < LINE_CLKS; c++) begin
            k = (c - 96) / 4;
            lvl = ((k < 16) ? k[0] : bits[k % 32]) ? 8'hD0 : 8'h20;
            // Unselected input stays flat at blanking level
            sampleA = (onB || c < 96) ? 8'h40 : lvl;
            sampleB = (onB && c >= 96) ? lvl : 8'h40;
            @(negedge clock);
         end
      end
      horizRef = 1'b1;
   endtask
endmodule // vds_video_src

// ===== tb/tb_top.sv
/* Self-checking bench for the line slicer.
   Uses the front-end model and the bound port checker. */
`timescale 1ns/1ps
module tb_top;
   logic       clock, rst, horizRef, vertRef, fieldId, regWr, regRd;
   logic       textReady, textValid, textLast;
   logic [7:0] sampleA, sampleB, regAddr, regWrData, regRdData, textData, rd;
   int         num_errors, checks_done, lines, i;
   logic [7:0] corner [4] = '{8'h41, 8'h57, 8'h5B, 8'h62};

   vds_slicer #(.FIFO_DEPTH(16)) u_dut (.clock(clock), .rst(rst), .sampleA(sampleA),
      .sampleB(sampleB), .horizRef(horizRef), .vertRef(vertRef), .fieldId(fieldId),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .textData(textData), .textLast(textLast),
      .textValid(textValid), .textReady(textReady));
   vds_video_src #(.LINE_CLKS(480)) u_src (.clock(clock), .sampleA(sampleA), .sampleB(sampleB),
      .horizRef(horizRef), .vertRef(vertRef), .fieldId(fieldId));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      if (textValid === 1'b1 && textReady === 1'b1 && textLast === 1'b1) begin
         lines++;
      end
   end
   // ==================================================
   // Helpers
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   function automatic logic [7:0] rst_val(input logic [7:0] a);
      if (a >= 8'h41 && a <= 8'h57) return 8'hFF;
      return (a == 8'h5C) ? 8'hA7 : 8'h00;
   endfunction
   function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] d);
      if (a < 8'h40 || a == 8'h58 || (a > 8'h5D && a < 8'h62) || a > 8'h62) return 8'h00;
      return (a == 8'h62) ? (d & 8'hF0) : d;
   endfunction
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regWrData = d;
      regWr = 1'b1;
      @(negedge clock);
      regWr = 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock);
      regAddr = a;
      regRd = 1'b1;
      @(negedge clock);
      regRd = 1'b0;
      d = regRdData;
   endtask
   // Write, then two reads back to back at the same place
   task automatic wr_rd2(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] m;
      m = (a == 8'h62) ? 8'hF0 : 8'hFF;
      reg_wr(a, d);
      regRd = 1'b1;
      @(negedge clock);
      check("readback", regRdData & m, exp_rd(a, d));
      @(negedge clock);
      regRd = 1'b0;
      check("reread", regRdData & m, exp_rd(a, d));
   endtask
   task automatic traffic(input logic onB, input logic srcB, input logic [7:0] code,
                          input int expN);
      int g;
      reg_wr(8'h40, {1'b0, srcB, 6'h00});
      reg_wr(8'h44, code);
      lines = 0;
      u_src.run_field(onB, 1'b0);
      for (g = 0; g < 1500; g++) begin
         @(negedge clock);
         textReady = 1'($urandom_range(1));
      end
      @(negedge clock);
      textReady = 1'b0;
      check("lines per field", 8'(lines), 8'(expN));
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==================================================
   // Sequence
   initial begin
      #4_500_000;
      num_errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      {regAddr, regWrData, regWr, regRd, textReady} = '0;
      {num_errors, checks_done, lines} = '0;
      void'($urandom(13));
      repeat (8) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      for (i = 8'h40; i <= 8'h5C; i++) begin
         reg_rd(8'(i), rd);
         if (i != 8'h58) check("reset value", rd, rst_val(8'(i)));
      end
      reg_rd(8'h62, rd);
      check("type reset", rd & 8'hF0, 8'h00);
      for (i = 0; i < 40; i++) begin
         regAddr = 8'($urandom_range(8'h7F));
         if (i < 4) regAddr = corner[i];
         wr_rd2((regAddr == 8'h5D) ? 8'h5C : regAddr, 8'($urandom));
      end
      for (i = 8'h41; i <= 8'h57; i++) reg_wr(8'(i), 8'hFF);
      reg_wr(8'h59, 8'h10);
      reg_wr(8'h5A, 8'h00);
      reg_wr(8'h5B, 8'h00);
      traffic(1'b0, 1'b0, 8'h66, 1);
      traffic(1'b1, 1'b1, 8'h66, 1);
      traffic(1'b1, 1'b0, 8'h66, 0);
      traffic(1'b0, 1'b0, 8'hBB, 0);
      end_of_test();
   end
endmodule // tb_top
